// file: cpcg_clock_gen.v
// Purpose: CPU clock selection and division, peripheral clock enables,
//          clock output and bus clock pins, operating mode guarding
// Assumes: All oscillators arrive as one-cycle tick enables on i_core_clk
// Notes: Every derived clock except the toggling clock output pin is a one-cycle enable pulse, registered
`timescale 1ns/1ps
`default_nettype none
`include "cpcg_defs.vh"

module cpcg_clock_gen (
    input wire i_core_clk,
    input wire i_rst_b,
    input wire i_main_osc_tick,
    input wire i_sub_osc_tick,
    input wire i_ring_osc_tick,
    input wire i_pll_tick,
    input wire i_main_osc_stopped,
    input wire i_sub_osc_run,
    input wire i_single_chip_mode,
    input wire i_wait_mode,
    input wire i_stop_enter,
    input wire i_cfg_wr,
    input wire i_ring_osc_select,
    input wire i_osc_stop_detect_enable,
    input wire i_osc_stop_detect_irq_mode,
    input wire i_wdt_ring_source_select,
    input wire i_clock_mod_lock,
    input wire i_pll_enable,
    input wire i_cpu_src_pll_select,
    input wire i_cpu_src_sub_select,
    input wire i_pll_wait_state_select,
    input wire [2:0] i_pll_multiplier_code,
    input wire i_div8_force,
    input wire [1:0] i_cpu_divider_select,
    input wire i_bus_clock_out_disable,
    input wire i_main_osc_off,
    input wire i_periph_gate_in_wait,
    input wire [1:0] i_clk_out_select,
    output reg o_cpu_clk_en,
    output reg o_wdt_clk_en,
    output reg [3:0] o_timer_peripheral_clock,
    output reg [3:0] o_serial_peripheral_clock,
    output reg o_converter_clock,
    output reg o_sub_clock_div32,
    output reg o_sub_clock_out,
    output reg o_clock_output_pin,
    output reg o_clock_output_pin_oe,
    output reg o_bus_clock_pin,
    output reg o_bus_clock_pin_oe,
    output wire o_ring_osc_run,
    output wire o_pll_run,
    output wire o_main_osc_run,
    output reg [3:0] o_pll_mult_factor,
    output wire o_pll_two_waits,
    output wire o_div8_force,
    output wire o_ring_osc_select,
    output wire [2:0] o_mode,
    output reg o_mode_refused
);

    // ----------------------------------------
    // Functions
    // ----------------------------------------

    // Terminal count of the CPU divider for main and ring sources
    function [3:0] div_tc;
        input div8;
        input [1:0] sel;
        begin
            if (div8) begin
                div_tc = `CPCG_TC_DIV8;
            end else begin
                case (sel)
                    2'h0: div_tc = `CPCG_TC_DIV1;
                    2'h1: div_tc = `CPCG_TC_DIV2;
                    2'h2: div_tc = `CPCG_TC_DIV4;
                    default: div_tc = `CPCG_TC_DIV16;
                endcase
            end
        end
    endfunction

    // Operating mode from the clock control bits
    function [2:0] mode_of;
        input ring;
        input pll;
        input sub;
        input moff;
        input div8;
        input [1:0] sel;
        begin
            if (sub) begin
                mode_of = moff ? `CPCG_MODE_LPD : `CPCG_MODE_LOW;
            end else if (ring) begin
                mode_of = moff ? `CPCG_MODE_RLP : `CPCG_MODE_RING;
            end else if (pll) begin
                mode_of = `CPCG_MODE_PLL;
            end else if (div8 || sel != 2'h0) begin
                mode_of = `CPCG_MODE_MED;
            end else begin
                mode_of = `CPCG_MODE_HIGH;
            end
        end
    endfunction

    // True for the two sub clock modes
    function is_sub_mode;
        input [2:0] m;
        begin
            is_sub_mode = (m == `CPCG_MODE_LOW) || (m == `CPCG_MODE_LPD);
        end
    endfunction

    // True for the two ring oscillator modes
    function is_ring_mode;
        input [2:0] m;
        begin
            is_ring_mode = (m == `CPCG_MODE_RING) || (m == `CPCG_MODE_RLP);
        end
    endfunction

    // ----------------------------------------
    // Reset release
    // ----------------------------------------

    // Two flops so the release is clean against the clock
    reg rst_meta_b;
    reg rst_b;
    always @(posedge i_core_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            rst_meta_b <= 1'b0;
            rst_b <= 1'b0;
        end else begin
            rst_meta_b <= 1'b1;
            rst_b <= rst_meta_b;
        end
    end

    // ----------------------------------------
    // Control state
    // ----------------------------------------
    reg ring_sel;
    reg det_en;
    reg det_irq;
    reg wdt_ring;
    reg lock;
    reg pll_en;
    reg src_pll;
    reg src_sub;
    reg pll_wait;
    reg [2:0] mul_code;
    reg mul_done;
    reg div8;
    reg [1:0] div_sel;
    reg bclk_dis;
    reg main_off;
    reg gate_wait;
    reg [1:0] co_sel;

    wire [2:0] cur_mode = mode_of(ring_sel, src_pll, src_sub, main_off, div8, div_sel);

    // Mode the write would lead to, with locked bits kept
    wire w_ring = lock ? ring_sel : i_ring_osc_select;
    wire w_pll = lock ? src_pll : i_cpu_src_pll_select;
    wire w_moff = lock ? main_off : i_main_osc_off;
    wire [2:0] w_mode = mode_of(w_ring, w_pll, i_cpu_src_sub_select, w_moff,
        i_div8_force, i_cpu_divider_select);

    // Sub modes and ring modes never meet directly
    wire refuse = i_cfg_wr &&
        ((is_sub_mode(cur_mode) && is_ring_mode(w_mode)) ||
         (is_ring_mode(cur_mode) && is_sub_mode(w_mode)));
    wire take_src = i_cfg_wr && !refuse;

    // Main clock loss while the main clock drives the CPU
    wire auto_ring = det_en && det_irq && i_main_osc_stopped &&
        !src_pll && !src_sub && !ring_sel;

    // Main switched off from low-speed gives low power mode
    wire lpd_entry = take_src && cur_mode == `CPCG_MODE_LOW && w_moff && !main_off;

    // Stop entry from any non-sub mode
    wire stop_div8 = i_stop_enter && !is_sub_mode(cur_mode);

    // Write-once multiplier, only while the PLL is off
    wire mul_take = i_cfg_wr && !lock && !mul_done && !pll_en;

    // Software bits, with lock and force terms applied
    always @(posedge i_core_clk or negedge rst_b) begin
        if (!rst_b) begin
            ring_sel <= 1'b0;
            det_en <= 1'b0;
            det_irq <= 1'b0;
            wdt_ring <= 1'b0;
            lock <= 1'b0;
            pll_en <= 1'b0;
            src_pll <= 1'b0;
            src_sub <= 1'b0;
            pll_wait <= 1'b0;
            mul_code <= `CPCG_RST_MUL;
            mul_done <= 1'b0;
            div8 <= `CPCG_RST_DIV8;
            div_sel <= `CPCG_RST_DIVSEL;
            bclk_dis <= 1'b0;
            main_off <= 1'b0;
            gate_wait <= 1'b0;
            co_sel <= `CPCG_RST_CO;
            o_mode_refused <= 1'b0;
        end else begin
            o_mode_refused <= refuse;
            if (i_cfg_wr) begin
                det_irq <= i_osc_stop_detect_irq_mode;
                pll_wait <= i_pll_wait_state_select;
                bclk_dis <= i_bus_clock_out_disable;
                co_sel <= i_clk_out_select;
                div_sel <= i_cpu_divider_select;
                // Set-once: a later write cannot clear them
                wdt_ring <= wdt_ring | i_wdt_ring_source_select;
                lock <= lock | i_clock_mod_lock;
                if (!lock) begin
                    det_en <= i_osc_stop_detect_enable;
                    pll_en <= i_pll_enable;
                    gate_wait <= i_periph_gate_in_wait;
                end
            end
            if (take_src) begin
                src_sub <= i_cpu_src_sub_select;
                src_pll <= w_pll;
                main_off <= w_moff;
            end
            // Detection set wins over a write that clears the bit
            if (auto_ring) begin
                ring_sel <= 1'b1;
            end else if (take_src) begin
                ring_sel <= w_ring;
            end
            if (mul_take) begin
                mul_code <= i_pll_multiplier_code;
                mul_done <= 1'b1;
            end
            // Forced divide-by-8 wins over software
            if (stop_div8 || lpd_entry) begin
                div8 <= 1'b1;
            end else if (!ring_sel && main_off) begin
                div8 <= 1'b1;
            end else if (i_cfg_wr && cur_mode != `CPCG_MODE_LPD) begin
                div8 <= i_div8_force;
            end
        end
    end

    // ----------------------------------------
    // Oscillator runs and PLL factor
    // ----------------------------------------
    assign o_ring_osc_run = ring_sel | wdt_ring;
    assign o_pll_run = pll_en;
    assign o_main_osc_run = !main_off;
    assign o_pll_two_waits = !pll_wait;
    assign o_div8_force = div8;
    assign o_ring_osc_select = ring_sel;
    assign o_mode = cur_mode;

    // Ticks of sources that are really running
    wire main_tick = i_main_osc_tick & !main_off;
    wire ring_tick = i_ring_osc_tick & o_ring_osc_run;
    wire pll_tick = i_pll_tick & pll_en;
    wire sub_tick = i_sub_osc_tick & i_sub_osc_run;

    // Multiplying factor; unused codes leave the PLL at factor 0
    always @(posedge i_core_clk or negedge rst_b) begin
        if (!rst_b) begin
            o_pll_mult_factor <= 4'h0;
        end else begin
            case (mul_code)
                `CPCG_MUL_X2: o_pll_mult_factor <= 4'h2;
                `CPCG_MUL_X4: o_pll_mult_factor <= 4'h4;
                `CPCG_MUL_X6: o_pll_mult_factor <= 4'h6;
                `CPCG_MUL_X8: o_pll_mult_factor <= 4'h8;
                default: o_pll_mult_factor <= 4'h0;
            endcase
        end
    end

    // ----------------------------------------
    // CPU clock divider
    // ----------------------------------------

    // Requested source and ratio; sub and PLL run undivided
    wire [1:0] want_src = src_sub ? `CPCG_SRC_SUB :
        ring_sel ? `CPCG_SRC_RING :
        src_pll ? `CPCG_SRC_PLL : `CPCG_SRC_MAIN;
    wire [3:0] want_tc = (src_sub || (src_pll && !ring_sel)) ?
        `CPCG_TC_DIV1 : div_tc(div8, div_sel);

    reg [1:0] cur_src;
    reg [3:0] cur_tc;
    reg [3:0] div_cnt;
    reg src_tick;

    always @* begin
        case (cur_src)
            `CPCG_SRC_SUB: src_tick = sub_tick;
            `CPCG_SRC_RING: src_tick = ring_tick;
            `CPCG_SRC_PLL: src_tick = pll_tick;
            default: src_tick = main_tick;
        endcase
    end

    // A dead main clock would never reach a boundary, so it yields at once
    wire src_dead = cur_src == `CPCG_SRC_MAIN && (i_main_osc_stopped || main_off);
    wire wrap = src_tick && div_cnt >= cur_tc;

    // New source and ratio are taken at a period boundary, or at once from a dead main clock
    always @(posedge i_core_clk or negedge rst_b) begin
        if (!rst_b) begin
            cur_src <= `CPCG_SRC_MAIN;
            cur_tc <= `CPCG_TC_DIV8;
            div_cnt <= 4'h0;
            o_cpu_clk_en <= 1'b0;
        end else begin
            o_cpu_clk_en <= wrap;
            if (wrap || src_dead) begin
                div_cnt <= 4'h0;
                cur_src <= want_src;
                cur_tc <= want_tc;
            end else if (src_tick) begin
                div_cnt <= div_cnt + 4'h1;
            end
        end
    end

    // ----------------------------------------
    // Peripheral clocks
    // ----------------------------------------

    // Peripheral source: ring if selected, else PLL, else main
    wire per_tick = ring_sel ? ring_tick :
        (src_pll && !src_sub) ? pll_tick : main_tick;

    // Off in wait with gating, and throughout low power mode
    wire per_gate = (i_wait_mode && gate_wait) || cur_mode == `CPCG_MODE_LPD;

    reg [4:0] per_cnt;
    wire [3:0] per_en = {per_tick && per_cnt == 5'h1f,
        per_tick && per_cnt[2:0] == 3'h7,
        per_tick && per_cnt[0], per_tick};

    always @(posedge i_core_clk or negedge rst_b) begin
        if (!rst_b) begin
            per_cnt <= 5'h00;
            o_timer_peripheral_clock <= 4'h0;
            o_serial_peripheral_clock <= 4'h0;
            o_converter_clock <= 1'b0;
        end else begin
            if (per_tick && !per_gate) begin
                per_cnt <= per_cnt + 5'h01;
            end
            o_timer_peripheral_clock <= per_gate ? 4'h0 : per_en;
            o_serial_peripheral_clock <= per_gate ? 4'h0 : per_en;
            o_converter_clock <= per_tick && !per_gate;
        end
    end

    // ----------------------------------------
    // Sub clock divide-by-32
    // ----------------------------------------

    // Not gated by wait; it stops only with the sub oscillator
    reg [4:0] sub_cnt;
    always @(posedge i_core_clk or negedge rst_b) begin
        if (!rst_b) begin
            sub_cnt <= 5'h00;
            o_sub_clock_div32 <= 1'b0;
            o_sub_clock_out <= 1'b0;
        end else begin
            o_sub_clock_out <= sub_tick;
            o_sub_clock_div32 <= sub_tick && sub_cnt == 5'h1f;
            if (sub_tick) begin
                sub_cnt <= sub_cnt + 5'h01;
            end
        end
    end

    // ----------------------------------------
    // Watchdog, clock output and bus clock pins
    // ----------------------------------------

    // Clock output toggles on the chosen enable, so it halves its rate
    reg co_tick;
    always @* begin
        case (co_sel)
            `CPCG_CO_SUB: co_tick = sub_tick;
            `CPCG_CO_DIV8: co_tick = per_en[2] && !per_gate;
            `CPCG_CO_DIV32: co_tick = per_en[3] && !per_gate;
            default: co_tick = 1'b0;
        endcase
    end

    wire co_on = i_single_chip_mode && co_sel != `CPCG_CO_PORT;
    wire bclk_on = !i_single_chip_mode && !bclk_dis;

    always @(posedge i_core_clk or negedge rst_b) begin
        if (!rst_b) begin
            o_wdt_clk_en <= 1'b0;
            o_clock_output_pin <= 1'b0;
            o_clock_output_pin_oe <= 1'b0;
            o_bus_clock_pin <= 1'b0;
            o_bus_clock_pin_oe <= 1'b0;
        end else begin
            // Ring source keeps the watchdog alive even in wait
            o_wdt_clk_en <= wdt_ring ? ring_tick : wrap;
            o_clock_output_pin_oe <= co_on;
            if (!co_on) begin
                o_clock_output_pin <= 1'b0;
            end else if (co_tick) begin
                o_clock_output_pin <= !o_clock_output_pin;
            end
            // One high per CPU clock period keeps the frequency equal
            o_bus_clock_pin_oe <= bclk_on;
            o_bus_clock_pin <= bclk_on && wrap;
        end
    end

endmodule

`default_nettype wire

// file: cpcg_clock_gen_properties.sv
// Purpose: Port-level checks of the clock generator
// Assumes: Oscillator ticks are one-cycle pulses on i_core_clk
// Notes: Bound into cpcg_clock_gen below
`timescale 1ns/1ps
`default_nettype none
`include "cpcg_defs.vh"

module cpcg_clock_gen_properties (
    input wire logic i_core_clk,
    input wire logic i_rst_b,
    input wire logic i_main_osc_tick,
    input wire logic i_sub_osc_tick,
    input wire logic i_ring_osc_tick,
    input wire logic i_pll_tick,
    input wire logic i_sub_osc_run,
    input wire logic i_stop_enter,
    input wire logic o_cpu_clk_en,
    input wire logic o_wdt_clk_en,
    input wire logic [3:0] o_timer_peripheral_clock,
    input wire logic [3:0] o_serial_peripheral_clock,
    input wire logic o_converter_clock,
    input wire logic o_sub_clock_out,
    input wire logic o_bus_clock_pin,
    input wire logic o_ring_osc_run,
    input wire logic o_main_osc_run,
    input wire logic [3:0] o_pll_mult_factor,
    input wire logic o_div8_force,
    input wire logic o_ring_osc_select,
    input wire logic [2:0] o_mode
);
    // ----------------------------------------
    // Checks
    // ----------------------------------------
    default clocking @(posedge i_core_clk); endclocking
    default disable iff (!i_rst_b);

    ring_runs_sel_a: assert property (o_ring_osc_select |-> o_ring_osc_run)
        else $error("ring selected but not running");
    wdt_tick_cause_a: assert property (o_wdt_clk_en |-> $past(i_ring_osc_tick) || o_cpu_clk_en || $past(o_cpu_clk_en))
        else $error("watchdog pulse without cause");
    // Factor other than 0 or 2, the two seen after reset, is locked until the next reset
    pll_factor_once_a: assert property (o_pll_mult_factor != 4'h0 && o_pll_mult_factor != 4'h2 |=> $stable(o_pll_mult_factor))
        else $error("multiplier factor changed twice");
    cpu_tick_cause_a: assert property (o_cpu_clk_en |-> $past(i_main_osc_tick || i_sub_osc_tick || i_ring_osc_tick || i_pll_tick))
        else $error("cpu pulse without source tick");
    bus_follows_cpu_a: assert property (o_bus_clock_pin |-> o_cpu_clk_en)
        else $error("bus clock out of step with cpu clock");
    stop_forces_div8_a: assert property (i_stop_enter && o_mode >= `CPCG_MODE_HIGH && o_mode != `CPCG_MODE_LOW && o_mode != `CPCG_MODE_LPD |=> o_div8_force)
        else $error("stop entry did not force div8");
    // Divided pulses coincide with the faster ones, serial and converter track timer
    periph_nesting_a: assert property (o_timer_peripheral_clock[3] |-> &o_timer_peripheral_clock[2:0] && o_serial_peripheral_clock == o_timer_peripheral_clock && o_converter_clock)
        else $error("peripheral clocks not nested");
    lpd_gates_periph_a: assert property ((o_mode == `CPCG_MODE_LPD) [*2] |-> o_timer_peripheral_clock == 4'h0 && !o_converter_clock)
        else $error("peripheral clock in low power mode");
    sub_tick_cause_a: assert property (o_sub_clock_out |-> $past(i_sub_osc_tick && i_sub_osc_run))
        else $error("sub clock without running sub tick");
    low_to_ring_a: assert property (o_mode == `CPCG_MODE_LOW || o_mode == `CPCG_MODE_LPD |=> o_mode != `CPCG_MODE_RING && o_mode != `CPCG_MODE_RLP)
        else $error("direct move from sub modes to ring modes");
    ring_to_low_a: assert property (o_mode == `CPCG_MODE_RING || o_mode == `CPCG_MODE_RLP |=> o_mode != `CPCG_MODE_LOW && o_mode != `CPCG_MODE_LPD)
        else $error("direct move from ring modes to sub modes");
    main_off_div8_a: assert property ((!o_ring_osc_select && !o_main_osc_run) [*2] |-> o_div8_force)
        else $error("div8 not held with main and ring off");
endmodule

bind cpcg_clock_gen cpcg_clock_gen_properties cpcg_clock_gen_properties_i (.*);
`default_nettype wire

// file: cpcg_clock_gen_tb_top.sv
// Purpose: Self-checking bench of the clock generator
// Assumes: Tick ratios of cpcg_osc_model, 320-cycle count windows
// Notes: Counts are exact since every window spans whole periods
`timescale 1ns/1ps
`default_nettype none
`include "cpcg_defs.vh"

module cpcg_clock_gen_tb_top;
    logic i_core_clk = 1'b0, i_rst_b = 1'b0, i_cfg_wr = 1'b0, i_stop_enter = 1'b0, i_wait_mode = 1'b0;
    logic i_main_osc_tick, i_sub_osc_tick, i_ring_osc_tick, i_pll_tick, i_main_osc_stopped = 1'b0;
    logic i_sub_osc_run = 1'b1, i_single_chip_mode = 1'b0, i_ring_osc_select = 1'b0, i_clock_mod_lock = 1'b0;
    logic i_osc_stop_detect_enable = 1'b0, i_osc_stop_detect_irq_mode = 1'b0, i_wdt_ring_source_select = 1'b0;
    logic i_pll_enable = 1'b0, i_cpu_src_pll_select = 1'b0, i_cpu_src_sub_select = 1'b0, i_main_osc_off = 1'b0;
    logic i_pll_wait_state_select = 1'b0, i_div8_force = 1'b1, i_bus_clock_out_disable = 1'b0;
    logic i_periph_gate_in_wait = 1'b0;
    logic [2:0] i_pll_multiplier_code = 3'h1;
    logic [1:0] i_cpu_divider_select = 2'h0, i_clk_out_select = 2'h0;
    logic o_cpu_clk_en, o_wdt_clk_en, o_converter_clock, o_sub_clock_div32, o_sub_clock_out, o_ring_osc_run;
    logic o_clock_output_pin, o_clock_output_pin_oe, o_bus_clock_pin, o_bus_clock_pin_oe, o_mode_refused;
    logic o_pll_run, o_main_osc_run, o_pll_two_waits, o_div8_force, o_ring_osc_select, co_q = 1'b0;
    logic [3:0] o_timer_peripheral_clock, o_serial_peripheral_clock, o_pll_mult_factor;
    logic [2:0] o_mode;
    int n[9], d[9], b[9], rf, n_fail = 0, cmp_count = 0;

    always #25 i_core_clk = ~i_core_clk;

    cpcg_osc_model cpcg_osc_model_i (
        .i_clk(i_core_clk),
        .i_main_halt(i_main_osc_stopped),
        .o_main_tick(i_main_osc_tick),
        .o_sub_tick(i_sub_osc_tick),
        .o_ring_tick(i_ring_osc_tick),
        .o_pll_tick(i_pll_tick)
    );
    cpcg_clock_gen cpcg_clock_gen_i (.*);

    // Pulse and toggle counters, read only on falling edges to avoid races
    always @(posedge i_core_clk) begin
        n[0] += o_cpu_clk_en;
        n[1] += o_bus_clock_pin;
        n[2] += o_timer_peripheral_clock[0];
        n[3] += o_timer_peripheral_clock[2];
        n[4] += o_timer_peripheral_clock[3];
        n[5] += (o_clock_output_pin != co_q);
        n[6] += o_wdt_clk_en;
        n[7] += o_mode_refused;
        n[8] += o_sub_clock_out;
        co_q <= o_clock_output_pin;
    end

    // ----------------------------------------
    // Tasks
    // ----------------------------------------
    task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
        cmp_count++;
        if (g !== e) begin
            n_fail++;
            $display("wrong value %s expected %0d seen %0d", s, e, g);
        end
    endtask
    task automatic wr;
        i_cfg_wr <= 1'b1;
        @(posedge i_core_clk);
        i_cfg_wr <= 1'b0;
    endtask
    // Settle past any pending divider wrap, then count one window
    task automatic meas;
        repeat (64) @(posedge i_core_clk);
        @(negedge i_core_clk);
        b = n;
        repeat (320) @(negedge i_core_clk);
        foreach (d[k]) d[k] = n[k] - b[k];
    endtask
    task automatic final_report;
        $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    // Watchdog: the sequence needs about 6300 cycles
    initial begin
        repeat (15000) @(posedge i_core_clk);
        n_fail++;
        final_report;
    end

    // ----------------------------------------
    // Tests
    // ----------------------------------------
    initial begin
        repeat (10) @(posedge i_core_clk);
        i_rst_b <= 1'b1;
        repeat (3) @(negedge i_core_clk);
        chk("ring_run", 0, o_ring_osc_run);
        chk("pll_run", 0, o_pll_run);
        chk("mode", `CPCG_MODE_MED, o_mode);
        meas;
        chk("cpu", 20, d[0]);
        chk("bus", 20, d[1]);
        chk("f1", 160, d[2]);
        chk("f8", 20, d[3]);
        chk("f32", 5, d[4]);
        chk("sub", 20, d[8]);
        @(posedge i_core_clk);
        i_pll_multiplier_code <= 3'h3;
        wr;
        @(posedge i_core_clk);
        i_pll_multiplier_code <= 3'h4;
        wr;
        repeat (2) @(negedge i_core_clk);
        chk("factor", 6, o_pll_mult_factor);
        for (int k = 0; k < 4; k++) begin
            @(posedge i_core_clk);
            i_div8_force <= 1'b0;
            i_cpu_divider_select <= k[1:0];
            wr;
            meas;
            chk("cpu", 160 >> (k + (k == 3)), d[0]);
            chk("bus", 160 >> (k + (k == 3)), d[1]);
            chk("mode", k == 0 ? `CPCG_MODE_HIGH : `CPCG_MODE_MED, o_mode);
        end
        for (int k = 1; k < 4; k++) begin
            @(posedge i_core_clk);
            i_single_chip_mode <= 1'b1;
            i_clk_out_select <= k[1:0];
            wr;
            meas;
            chk("co_toggles", k == 3 ? 5 : 20, d[5]);
            chk("co_oe", 1, o_clock_output_pin_oe);
            chk("bus_oe", 0, o_bus_clock_pin_oe);
        end
        @(posedge i_core_clk);
        i_cpu_divider_select <= 2'h0;
        i_pll_enable <= 1'b1;
        wr;
        @(negedge i_core_clk);
        chk("pll_run", 1, o_pll_run);
        repeat (64) @(posedge i_core_clk); // Settle wait
        i_cpu_src_pll_select <= 1'b1;
        wr;
        meas;
        chk("cpu", 320, d[0]);
        chk("f1", 320, d[2]);
        chk("mode", `CPCG_MODE_PLL, o_mode);
        chk("waits", 1, o_pll_two_waits);
        @(posedge i_core_clk);
        i_cpu_src_pll_select <= 1'b0;
        wr;
        @(posedge i_core_clk);
        i_pll_enable <= 1'b0;
        i_stop_enter <= 1'b1;
        wr;
        i_stop_enter <= 1'b0;
        @(negedge i_core_clk);
        chk("div8", 1, o_div8_force);
        @(posedge i_core_clk);
        i_periph_gate_in_wait <= 1'b1;
        i_wait_mode <= 1'b1;
        i_div8_force <= 1'b1;
        wr;
        meas;
        chk("f1", 0, d[2]);
        chk("sub", 20, d[8]);
        @(posedge i_core_clk);
        i_wait_mode <= 1'b0;
        i_osc_stop_detect_enable <= 1'b1;
        i_osc_stop_detect_irq_mode <= 1'b1;
        wr;
        @(posedge i_core_clk);
        i_main_osc_stopped <= 1'b1;
        i_ring_osc_select <= 1'b1;
        repeat (3) @(negedge i_core_clk);
        chk("ring_sel", 1, o_ring_osc_select);
        meas;
        chk("cpu", 10, d[0]);
        chk("f1", 80, d[2]);
        @(posedge i_core_clk);
        i_wdt_ring_source_select <= 1'b1;
        i_div8_force <= 1'b0;
        wr;
        meas;
        chk("wdt", 80, d[6]);
        chk("cpu", 80, d[0]);
        @(posedge i_core_clk);
        i_main_osc_stopped <= 1'b0;
        i_div8_force <= 1'b1;
        wr;
        @(posedge i_core_clk);
        i_ring_osc_select <= 1'b0;
        wr;
        meas;
        chk("mode", `CPCG_MODE_MED, o_mode);
        @(posedge i_core_clk);
        i_cpu_src_sub_select <= 1'b1;
        wr;
        meas;
        chk("cpu", 20, d[0]);
        chk("f1", 160, d[2]);
        rf = n[7];
        @(posedge i_core_clk);
        {i_ring_osc_select, i_cpu_src_sub_select} <= 2'h2;
        wr;
        {i_ring_osc_select, i_cpu_src_sub_select} <= 2'h1;
        meas;
        chk("refused", 1, n[7] - rf);
        chk("mode", `CPCG_MODE_LOW, o_mode);
        @(posedge i_core_clk);
        i_main_osc_off <= 1'b1;
        wr;
        meas;
        chk("mode", `CPCG_MODE_LPD, o_mode);
        chk("div8", 1, o_div8_force);
        chk("f1", 0, d[2]);
        @(posedge i_core_clk);
        i_clock_mod_lock <= 1'b1;
        wr;
        @(posedge i_core_clk);
        i_pll_enable <= 1'b1;
        wr;
        @(negedge i_core_clk);
        chk("pll_run", 0, o_pll_run);
        final_report;
    end
endmodule
`default_nettype wire

// file: cpcg_defs.vh
// Purpose: Constants of the CPU and peripheral clock generator
// Assumes: Included by cpcg_clock_gen.v, the property module and the bench
// Notes: Definitions only
`ifndef CPCG_DEFS_VH
`define CPCG_DEFS_VH

// ----------------------------------------
// Source codes of the CPU clock
// ----------------------------------------
`define CPCG_SRC_MAIN 2'h0
`define CPCG_SRC_SUB 2'h1
`define CPCG_SRC_RING 2'h2
`define CPCG_SRC_PLL 2'h3

// ----------------------------------------
// Operating mode codes
// ----------------------------------------
`define CPCG_MODE_PLL 3'h0
`define CPCG_MODE_HIGH 3'h1
`define CPCG_MODE_MED 3'h2
`define CPCG_MODE_LOW 3'h3
`define CPCG_MODE_LPD 3'h4
`define CPCG_MODE_RING 3'h5
`define CPCG_MODE_RLP 3'h6

// ----------------------------------------
// Divider terminal counts (ratio minus one)
// ----------------------------------------
`define CPCG_TC_DIV1 4'h0
`define CPCG_TC_DIV2 4'h1
`define CPCG_TC_DIV4 4'h3
`define CPCG_TC_DIV8 4'h7
`define CPCG_TC_DIV16 4'hf

// ----------------------------------------
// Clock output select and PLL multiplier codes
// ----------------------------------------
`define CPCG_CO_PORT 2'h0
`define CPCG_CO_SUB 2'h1
`define CPCG_CO_DIV8 2'h2
`define CPCG_CO_DIV32 2'h3
`define CPCG_MUL_X2 3'h1
`define CPCG_MUL_X4 3'h2
`define CPCG_MUL_X6 3'h3
`define CPCG_MUL_X8 3'h4

// ----------------------------------------
// Reset values
// ----------------------------------------
`define CPCG_RST_DIV8 1'h1
`define CPCG_RST_DIVSEL 2'h0
`define CPCG_RST_MUL 3'h1
`define CPCG_RST_CO 2'h0

`endif

// file: cpcg_osc_model.sv
// Purpose: Oscillator tick source on the far side of the clock generator
// Assumes: Ticks are one-cycle pulses on the core clock
// Notes: Main every 2, ring every 4, sub every 16 cycles, PLL every cycle
`timescale 1ns/1ps
`default_nettype none

module cpcg_osc_model (
    input wire logic i_clk,
    input wire logic i_main_halt,
    output wire logic o_main_tick,
    output wire logic o_sub_tick,
    output wire logic o_ring_tick,
    output wire logic o_pll_tick
);
    // ----------------------------------------
    // Model
    // ----------------------------------------
    logic [3:0] phase = 4'h0;

    // Fixed ratios keep pulse counts exact over whole windows
    always @(posedge i_clk) begin
        phase <= phase + 4'h1;
    end
    assign o_main_tick = !i_main_halt && phase[0]; // Stopped main gives no ticks
    assign o_sub_tick = phase == 4'hf;
    assign o_ring_tick = phase[1:0] == 2'h3;
    assign o_pll_tick = 1'b1; // Only a settled PLL is modelled
endmodule
`default_nettype wire
